//--- core/flc_map.svh
// Register offsets, command bytes, status bit positions and timing counts of the flash lock controller.
`ifndef FLC_MAP_SVH
`define FLC_MAP_SVH
`define FLC_OFF_CTRL     12'h000
`define FLC_OFF_ADDR     12'h004
`define FLC_OFF_STATUS   12'h008
`define FLC_OFF_RESULT   12'h00c
`define FLC_CMD_STATUS   8'h70
`define FLC_CMD_SETUP    8'h60
`define FLC_CMD_BLOCK    8'h01
`define FLC_CMD_PERM     8'hf1
`define FLC_CMD_CLEARALL 8'hd0
`define FLC_CMD_CLRSR    8'h50
`define FLC_CMD_ARRAY    8'hff
`define FLC_SR_READY     7
`define FLC_SR_ECERR     5
`define FLC_SR_WSERR     4
`define FLC_SR_VPERR     3
`define FLC_SR_PROT      1
`define FLC_SR_ERRMASK   8'h3a
`define FLC_SR_RSVMASK   8'hfe
`define FLC_PULSE_NS     80
`define FLC_CLK_NS       8
`define FLC_PULSE_CYC    (((`FLC_PULSE_NS) + (`FLC_CLK_NS) - 1) / (`FLC_CLK_NS))
`define FLC_CNT_W        5
`define FLC_CMD_W        3
`endif

//--- core/flc_pkg.sv
// Types shared by the flash lock controller.
package flc_pkg;
  typedef enum logic [2:0] {
    FLC_OP_SETBLK   = 3'h1,
    FLC_OP_SETPERM  = 3'h2,
    FLC_OP_CLRALL   = 3'h3,
    FLC_OP_CLRSTAT  = 3'h4,
    FLC_OP_ARRAY    = 3'h5,
    FLC_OP_RDSTAT   = 3'h6
  } flc_op_e;
  typedef enum logic [7:0] {
    FLC_IDLE  = 8'h01,
    FLC_WRITE = 8'h02,
    FLC_GAP   = 8'h04,
    FLC_READ  = 8'h08,
    FLC_CHECK = 8'h10,
    FLC_NEXT  = 8'h20,
    FLC_DONE  = 8'h40,
    FLC_WAIT  = 8'h80
  } flc_state_e;
endpackage

//--- core/flc_ctrl.sv
// Host controller that drives a parallel flash through lock-bit and status command sequences.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "flc_map.svh"

// Notes on behaviour
// R1: Write read-status, poll until ready bit high before each lock-bit command.
// R2: Lock-bit set begins with setup byte 60H at any address.
// R3: Second byte 01H at block address sets block lock; F1H sets permanent lock.
// R4: After the last set operation, write FFH to return to array reads.
// R5: Clear all lock-bits is 60H then D0H; then FFH for array reads.
// R6: Device accumulates error bits 5,4,3,1 across several set operations.
// R7: Error bits 5,4,3,1 clear only by the clear-status command; here a reset pulse clears them as well.
// R8: Bits 4 and 5 together mean an invalid command sequence.
// R9: Failed clear sets bit 5; failed set sets bit 4.
// R10: Permanent lock already set aborts block set or clear, sets bit 1.
// R11: Chip erase with all blocks locked sets bit 1 and aborts.
// R12: Failed chip erase sets bit 5.
// R13: After any error, issue clear-status before retrying or recovering.
// R14: Full error check may follow each set or a whole series.
// R15: Ready/busy is open drain, always active, needs a pull-up.
// R16: Ready/busy goes low on accepted command, released when the machine finishes.
// R17: Ready/busy floats in suspend and reset modes.
// R18: Deselected device keeps outputs off; host selects only when accessing.
// R19: Host masks reserved status bit 0 while polling.
// R20: Reset during an operation keeps ready/busy low, then aborts.
// R21: Reset or power-off clears the whole status register.
module flc_ctrl #(
  parameter int ADDR_W = 20
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [ADDR_W-1:0]   flash_addr,
  input  wire logic [7:0]          flash_dq_in,
  output logic      [7:0]          flash_dq_out,
  output logic                     flash_dq_oe,
  output logic                     flash_ce_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n,
  output logic                     reset_powerdown_n,
  input  wire logic                ready_busy_n_out
);
  import flc_pkg::*;

  // The target register is read back with zero fill inside one word, so the width stops short of 32.
  if (ADDR_W < 1 || ADDR_W > 31) begin : g_addr_w_check
    $error("flc_ctrl: ADDR_W must be 1..31");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    flc_state_e                 st;
    logic [`FLC_CMD_W-1:0]      op;
    logic [1:0]                 step;
    logic                       poll;
    logic [`FLC_CNT_W-1:0]      cnt;
    logic [ADDR_W-1:0]          tgt;
    logic [7:0]                 sr;
    logic                       busy;
    logic                       done;
    logic                       err;
    logic                       need_clear;
    logic                       rst_req;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [ADDR_W-1:0]          faddr;
    logic [7:0]                 dq_out;
    logic                       dq_oe;
    logic                       ce_n;
    logic                       oe_n;
    logic                       we_n;
    logic                       rp_n;
  } flc_s;

  flc_s s_reg;
  flc_s s_next;

  // Byte for the current step of the running operation.
  function automatic logic [7:0] flc_step_byte(input logic [`FLC_CMD_W-1:0] op, input logic [1:0] step,
                                               input logic poll);
    logic [7:0] b;
    b = `FLC_CMD_ARRAY;
    if (poll) b = `FLC_CMD_STATUS;
    else begin
      unique case (flc_op_e'(op))
        FLC_OP_SETBLK:  b = (step == 2'd0) ? `FLC_CMD_SETUP : `FLC_CMD_BLOCK;
        FLC_OP_SETPERM: b = (step == 2'd0) ? `FLC_CMD_SETUP : `FLC_CMD_PERM;
        FLC_OP_CLRALL:  b = (step == 2'd0) ? `FLC_CMD_SETUP : `FLC_CMD_CLEARALL;
        FLC_OP_CLRSTAT: b = `FLC_CMD_CLRSR;
        FLC_OP_RDSTAT:  b = `FLC_CMD_STATUS;
        default:        b = `FLC_CMD_ARRAY;
      endcase
    end
    return b;
  endfunction

  function automatic logic flc_two_step(input logic [`FLC_CMD_W-1:0] op);
    return (op == FLC_OP_SETBLK) || (op == FLC_OP_SETPERM) || (op == FLC_OP_CLRALL);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic acc;
    logic [7:0] sr_m;
    logic rst_set;
    acc = 1'b0;
    sr_m = 8'h00;
    rst_set = 1'b0;
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.done = 1'b0;
    acc = psel && penable && !s_reg.pready;

    // APB slave: one wait state, every access answered on the second access cycle.
    if (acc) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          `FLC_OFF_CTRL: begin
            // A pending reset pulse owns the pins, so no operation may start beside it.
            if (!s_reg.busy && !s_reg.rst_req && pwdata[`FLC_CMD_W-1:0] != '0) begin
              // Lock-bit work is refused until the error state has been cleared.
              if (s_reg.need_clear && flc_two_step(pwdata[`FLC_CMD_W-1:0])) begin
                s_next.pslverr = 1'b1; // R13
              end else begin
                s_next.op = pwdata[`FLC_CMD_W-1:0];
                s_next.step = 2'd0;
                s_next.poll = flc_two_step(pwdata[`FLC_CMD_W-1:0]); // R1
                s_next.busy = 1'b1;
                s_next.st = FLC_WRITE;
                s_next.cnt = '0;
              end
            end else if (pwdata[8]) begin
              s_next.rst_req = 1'b1;
              rst_set = 1'b1;
            end else begin
              s_next.pslverr = 1'b1;
            end
          end
          `FLC_OFF_ADDR: s_next.tgt = pwdata[ADDR_W-1:0];
          default:       s_next.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          `FLC_OFF_CTRL:   s_next.prdata = {29'h0, s_reg.op};
          `FLC_OFF_ADDR:   s_next.prdata = {{(32-ADDR_W){1'b0}}, s_reg.tgt};
          `FLC_OFF_STATUS: s_next.prdata = {28'h0, s_reg.need_clear, s_reg.err, ~ready_busy_n_out, s_reg.busy};
          `FLC_OFF_RESULT: s_next.prdata = {24'h0, s_reg.sr};
          default:         s_next.pslverr = 1'b1;
        endcase
      end
    end

    unique case (s_reg.st)
      FLC_IDLE: begin
        s_next.ce_n = 1'b1; // R18
        s_next.oe_n = 1'b1;
        s_next.we_n = 1'b1;
        s_next.dq_oe = 1'b0;
        s_next.rp_n = 1'b1;
        if (s_reg.rst_req) begin
          // Pulse the reset pin; the device loses its whole status register.
          s_next.rp_n = 1'b0;
          s_next.sr = 8'h00; // R21
          s_next.need_clear = 1'b0;
          s_next.err = 1'b0;
          // A request written in this very cycle wins over the clear and gives a second pulse.
          s_next.rst_req = rst_set;
          s_next.busy = 1'b1;
          s_next.cnt = '0;
          s_next.st = FLC_WAIT;
        end
      end
      FLC_WRITE: begin
        s_next.ce_n = 1'b0;
        s_next.we_n = 1'b0;
        s_next.oe_n = 1'b1;
        s_next.dq_oe = 1'b1;
        s_next.dq_out = flc_step_byte(s_reg.op, s_reg.step, s_reg.poll); // R2 R3 R5
        // Block set needs the block address on confirm; other bytes go anywhere.
        s_next.faddr = (s_reg.op == FLC_OP_SETBLK && !s_reg.poll && s_reg.step == 2'd1) ? s_reg.tgt : '0; // R3
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == `FLC_CNT_W'(`FLC_PULSE_CYC)) begin
          s_next.we_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = FLC_GAP;
        end
      end
      FLC_GAP: begin
        s_next.ce_n = 1'b1;
        s_next.dq_oe = 1'b0;
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == `FLC_CNT_W'(`FLC_PULSE_CYC)) begin
          s_next.cnt = '0;
          if (s_reg.poll || (s_reg.op == FLC_OP_RDSTAT)) s_next.st = FLC_READ;
          else if (flc_two_step(s_reg.op) && s_reg.step == 2'd0) begin
            s_next.step = 2'd1;
            s_next.st = FLC_WRITE;
          end else if (flc_two_step(s_reg.op)) begin
            // After confirm the device answers reads with status until told otherwise.
            s_next.step = 2'd2;
            s_next.st = FLC_READ;
          end else begin
            if (s_reg.op == FLC_OP_CLRSTAT) begin
              s_next.sr = s_reg.sr & ~`FLC_SR_ERRMASK; // R7
              s_next.need_clear = 1'b0;
              s_next.err = 1'b0;
            end
            s_next.st = FLC_DONE;
          end
        end
      end
      FLC_READ: begin
        s_next.ce_n = 1'b0;
        s_next.oe_n = 1'b0;
        s_next.dq_oe = 1'b0;
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == `FLC_CNT_W'(`FLC_PULSE_CYC)) begin
          s_next.sr = flash_dq_in & `FLC_SR_RSVMASK; // R19
          s_next.oe_n = 1'b1;
          s_next.ce_n = 1'b1;
          s_next.cnt = '0;
          s_next.st = FLC_CHECK;
        end
      end
      FLC_CHECK: begin
        // Ready pin low means busy; the poll goes on while either source says busy.
        if (!s_reg.sr[`FLC_SR_READY] || !ready_busy_n_out) begin // R16
          s_next.st = FLC_READ;
        end else if (s_reg.poll) begin
          s_next.poll = 1'b0; // R1
          s_next.st = FLC_WRITE;
        end else begin
          s_next.st = FLC_NEXT;
        end
      end
      FLC_NEXT: begin
        sr_m = s_reg.sr & `FLC_SR_ERRMASK;
        if (sr_m != 8'h00) begin // R14
          // Any of bits 5,4,3,1 (including 4 and 5 together) counts as an error.
          s_next.err = 1'b1; // R8 R9 R10
          s_next.need_clear = 1'b1; // R13
        end
        if (flc_two_step(s_reg.op)) begin
          s_next.op = FLC_OP_ARRAY; // R4 R5
          s_next.poll = 1'b0;
          s_next.step = 2'd0;
          s_next.st = FLC_WRITE;
        end else begin
          s_next.st = FLC_DONE;
        end
      end
      FLC_DONE: begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.st = FLC_IDLE;
      end
      FLC_WAIT: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == `FLC_CNT_W'(`FLC_PULSE_CYC)) begin
          s_next.rp_n = 1'b1;
          s_next.busy = 1'b0;
          s_next.cnt = '0;
          s_next.st = FLC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: FLC_IDLE, op: '0, step: 2'd0, poll: 1'b0, cnt: '0, tgt: '0, sr: 8'h00,
                 busy: 1'b0, done: 1'b0, err: 1'b0, need_clear: 1'b0, rst_req: 1'b0, prdata: 32'h0000_0000,
                 pready: 1'b0, pslverr: 1'b0, faddr: '0, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                 oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata            = s_reg.prdata;
  assign pready            = s_reg.pready;
  assign pslverr           = s_reg.pslverr;
  assign flash_addr        = s_reg.faddr;
  assign flash_dq_out      = s_reg.dq_out;
  assign flash_dq_oe       = s_reg.dq_oe;
  assign flash_ce_n        = s_reg.ce_n;
  assign flash_oe_n        = s_reg.oe_n;
  assign flash_we_n        = s_reg.we_n;
  assign reset_powerdown_n = s_reg.rp_n;
endmodule
`default_nettype wire

//--- test/flc_ctrl_props.sv
// Checker of the flash lock controller's bus answers and flash strobes.
`timescale 1ns/1ns
`default_nettype none
module flc_ctrl_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] flash_dq_out,
  input wire logic       flash_dq_oe,
  input wire logic       flash_ce_n,
  input wire logic       flash_oe_n,
  input wire logic       flash_we_n,
  input wire logic       ready_busy_n_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       we_d;
  logic       wfall;
  logic [7:0] last_cmd;
  assign wfall = !flash_we_n && we_d;
  // Remembers the byte of the previous flash write, so command pairs can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_d     <= 1'b1;
      last_cmd <= 8'h00;
    end else begin
      we_d <= flash_we_n;
      if (wfall) last_cmd <= flash_dq_out;
    end
  end
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_slverr; pslverr |-> pready; endproperty
  a_slverr: assert property (p_slverr) else $error("error without ready");
  property p_select; !flash_oe_n || !flash_we_n |-> !flash_ce_n; endproperty
  a_select: assert property (p_select) else $error("strobe while deselected");
  property p_drive; flash_dq_oe |-> flash_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("bus contention");
  property p_wepulse; wfall |=> (!flash_we_n && $stable(flash_dq_out)) [*8]; endproperty
  a_wepulse: assert property (p_wepulse) else $error("short write pulse");
  property p_confirm; wfall && flash_dq_out inside {8'h01, 8'hf1, 8'hd0} |-> last_cmd == 8'h60; endproperty
  a_confirm: assert property (p_confirm) else $error("confirm without setup");
  property p_setup; wfall && flash_dq_out == 8'h60 |-> last_cmd == 8'h70 && ready_busy_n_out; endproperty
  a_setup: assert property (p_setup) else $error("setup before ready");
  property p_array; wfall && last_cmd inside {8'h01, 8'hf1, 8'hd0} |-> flash_dq_out == 8'hff; endproperty
  a_array: assert property (p_array) else $error("no array mode after lock op");
  c_refuse: cover property (pslverr);
  c_clear: cover property (wfall && flash_dq_out == 8'hd0);
  c_perm: cover property (wfall && flash_dq_out == 8'hf1);
endmodule
bind flc_ctrl flc_ctrl_props flc_ctrl_props_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .flash_dq_out,
  .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .ready_busy_n_out);
`default_nettype wire

//--- test/flc_flash_model.sv
// Behavioural parallel flash: lock-bit commands, sticky status and open-drain ready/busy.
`timescale 1ns/1ns
`default_nettype none
module flc_flash_model (
  input  wire logic       clk,
  input  wire logic       ce_n,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  input  wire logic       rp_n,
  input  wire logic [7:0] dq,
  input  wire logic [19:0] addr,
  input  wire logic       perm,
  input  wire logic       fail,
  input  wire logic [7:0] dly,
  output logic      [7:0] q,
  output logic            rb
);
  logic [7:0] sr = 8'h80, cmd, op, rv;
  logic       we_d = 1'b1, setup = 1'b0, stat = 1'b0, ab = 1'b0, chip = 1'b0;
  logic [19:0] blk = '0;
  int         busy = 0;
  // Released pin reads high through the pull-up; the array byte is arbitrary.
  assign rb = busy == 0;
  assign rv = stat ? sr : 8'h5a;
  // An idle bus shows the inverse so a stale byte never passes for a read.
  assign q = (!ce_n && !oe_n && rp_n) ? rv : ~rv;
  always @(posedge clk) begin
    we_d <= we_n;
    if (!ce_n && !we_n) cmd <= dq;
    if (!ce_n && !we_n && setup && dq == 8'h01) blk <= addr;
    if (!rp_n) begin
      sr    <= 8'h80;
      setup <= 1'b0;
      chip  <= 1'b0;
      stat  <= 1'b0;
      ab    <= busy != 0;
    end else if (ab) begin
      busy <= 0;
      ab   <= 1'b0;
    end else if (busy != 0) begin
      busy <= busy - 1;
      if (busy == 1) begin
        sr[7] <= 1'b1;
        // For a chip erase the perm input stands for every block being locked.
        if (perm && op != 8'hf1) sr[1] <= 1'b1;
        else if (fail) sr[(op == 8'h01 || op == 8'hf1) ? 4 : 5] <= 1'b1;
      end
    end else if (we_n && !we_d) begin
      setup <= cmd == 8'h60;
      chip  <= cmd == 8'h30;
      if ((setup && cmd inside {8'h01, 8'hf1, 8'hd0}) || (chip && cmd == 8'hd0)) begin
        busy  <= dly + 1;
        op    <= chip ? 8'h30 : cmd;
        sr[7] <= 1'b0;
        stat  <= 1'b1;
      end else if (setup || chip) sr[5:4] <= 2'b11;
      else if (cmd == 8'h50) sr[5:1] <= 5'h00;
      else if (cmd == 8'h70 || cmd == 8'hff) stat <= cmd == 8'h70;
    end
  end
endmodule
`default_nettype wire

//--- test/test_flc_ctrl.sv
// Self-checking bench for the flash lock controller against a behavioural flash.
`timescale 1ns/1ns
`default_nettype none
`include "flc_map.svh"
module test_flc_ctrl;
  typedef struct packed {logic [2:0] op; logic perm; logic fail; logic [7:0] res; logic err;} flc_row_s;
  localparam flc_row_s ROWS [15] = '{'{1, 0, 0, 8'h80, 0}, '{2, 0, 0, 8'h80, 0}, '{3, 0, 0, 8'h80, 0},
    '{1, 0, 1, 8'h90, 1}, '{6, 0, 0, 8'h90, 1}, '{4, 0, 0, 8'h80, 0}, '{3, 0, 1, 8'ha0, 1}, '{4, 0, 0, 8'h80, 0},
    '{1, 1, 0, 8'h82, 1}, '{4, 0, 0, 8'h80, 0}, '{3, 1, 0, 8'h82, 1}, '{4, 0, 0, 8'h80, 0}, '{2, 1, 1, 8'h90, 1},
    '{4, 0, 0, 8'h80, 0}, '{5, 0, 0, 8'h80, 0}};
  logic        pclk, presetn, psel, penable, pwrite, perm, fail, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n, ready_busy_n_out;
  logic [19:0] flash_addr;
  logic [7:0]  flash_dq_in, flash_dq_out, mq, dly;
  int          failures, total_checks;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : mq;
  always #4 pclk = ~pclk;
  flc_ctrl flc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .reset_powerdown_n, .ready_busy_n_out);
  flc_flash_model flc_flash_model_i (.clk(pclk), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .rp_n(reset_powerdown_n), .dq(flash_dq_in), .addr(flash_addr), .perm, .fail, .dly, .q(mq),
    .rb(ready_busy_n_out));
  task automatic summarize();
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge and takes the answer at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    if (n >= 40) chk(32'h0, 32'h1);
    if (n >= 40) summarize();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle();
    int k;
    for (k = 0; k < 400; k++) begin
      apb(1'b0, `FLC_OFF_STATUS, 32'h0);
      if (rd[1:0] === 2'b00) break;
    end
    if (k >= 400) chk(32'h0, 32'h1);
    if (k >= 400) summarize();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, perm, fail, paddr, pwdata, dly} = '0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    chk({pready, flash_ce_n, flash_we_n, flash_dq_oe, reset_powerdown_n}, 5'b01101);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      perm <= ROWS[i].perm;
      fail <= ROWS[i].fail;
      dly  <= i[0] ? 8'd2 : 8'd60;
      apb(1'b1, `FLC_OFF_CTRL, {29'h0, ROWS[i].op});
      chk(er, 0);
      idle();
      apb(1'b0, `FLC_OFF_RESULT, 32'h0);
      chk(rd, {24'h0, ROWS[i].res});
      apb(1'b0, `FLC_OFF_STATUS, 32'h0);
      chk(rd[2], ROWS[i].err);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1);
    chk(rd, 32'h0);
    apb(1'b1, `FLC_OFF_CTRL, 32'h0);
    chk(er, 1);
    apb(1'b1, `FLC_OFF_ADDR, 32'h000a5);
    apb(1'b0, `FLC_OFF_ADDR, 32'h0);
    chk(rd, 32'h000a5);
    dly  <= 8'd60;
    fail <= 1'b1;
    apb(1'b1, `FLC_OFF_CTRL, 32'h1);
    chk(er, 0);
    apb(1'b1, `FLC_OFF_CTRL, 32'h1);
    chk(er, 1);
    idle();
    chk(flc_flash_model_i.blk, 32'h000a5);
    apb(1'b1, `FLC_OFF_CTRL, 32'h3);
    chk(er, 1);
    apb(1'b1, `FLC_OFF_CTRL, 32'h100);
    idle();
    apb(1'b0, `FLC_OFF_RESULT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `FLC_OFF_STATUS, 32'h0);
    chk(rd[3:2], 2'b00);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({pready, flash_ce_n, flash_we_n, flash_dq_oe}, 4'b0110);
    presetn <= 1'b1;
    apb(1'b0, `FLC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
